// ---- core/ir_ctl_pkg.sv ----
// Constants of the transceiver serial control slave
// Function
// - Each transaction opens with a command; only reads add a response.
// - The transceiver is slave only and never starts a transaction.
// - A response starts exactly four clocks after the last command bit.
// - Bytes within a phase follow back to back with no idle clocks.
// - Each byte is sent least significant bit first after one start bit.
// - Every receiver samples serial data on the rising serial clock edge.
// - The transceiver changes the read line on rising serial clock edges; the code releases the acknowledge pulse on the falling edge.
// - Outside commands the write line is the emitter LED transmit signal.
// - The first rising clock edge of a command disables the transmit LED.
// - LED is re-enabled on the last command clock; then no clock edges. A read re-enables it when the write line goes low.
// - During a read response the photodiode is cut off the read line.
// - An individually addressed slave drives read data even with its receiver disabled.
// - An unaddressed slave floats the read line during the transaction.
// - The end of a read is found by the write line going low.
// - With acknowledge on, the read line pulses low one clock after writes.
// - When idle the write line rests low and the read line high.
// - The transceiver answers address 001 and broadcast address 111.
// - Acknowledge needs both enables set and the individual address.
// - New configuration applies only after the command phase ends.
package ir_ctl_pkg;
	// ==========================================
	// Command byte layout and addresses
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_DIR_BIT = 3;
	localparam int CMD_IDX_LSB = 4;
	localparam logic [2:0] ADDR_INDIV = 3'h1;
	localparam logic [2:0] ADDR_BCAST = 3'h7;
	localparam logic [3:0] IDX_CTRL0 = 4'h0;
	localparam logic [3:0] IDX_CTRL1 = 4'h1;
	localparam logic [3:0] IDX_CTRL2 = 4'h2;
	localparam logic [3:0] IDX_RESET = 4'hd;
	// ==========================================
	// Control register fields and reset values
	localparam int C0_PWR = 0;
	localparam int C0_RXOEN = 1;
	localparam int C0_TLED = 2;
	localparam int C0_ACK_PULSE_ENABLE = 4;
	localparam logic [4:0] CTRL0_RST = 5'h14;
	localparam logic [3:0] CTRL1_RST = 4'h0;
	localparam logic [3:0] CTRL2_RST = 4'h7;
	// ==========================================
	// Bit and clock counts
	localparam logic [3:0] BYTE_LAST = 4'h7;
	localparam logic [3:0] WBYTE_LAST = 4'h8;
	localparam logic [3:0] RESP_GAP = 4'h4;
	localparam logic [3:0] GAP_LAST = RESP_GAP - 4'h1;
	localparam logic [4:0] INIT_EDGES = 5'h1e;
	localparam logic TX_START = 1'b1;
	localparam logic RX_START = 1'b0;
endpackage

// ---- core/ir_ctl_slave.sv ----
// Serial control slave of the infrared transceiver
`timescale 1ns/10ps
module ir_ctl_slave
	import ir_ctl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Serial bus pins from the controller
	input wire logic sclk,
	input wire logic tx_write_line,
	// Photodiode receiver signal
	input wire logic photo_rx,
	// Read line pin, two signals
	output logic rx_out,
	output logic rx_oe_n,
	// Emitter and configuration
	output logic led_drive,
	output logic power_mode,
	output logic receiver_output_enable,
	output logic ack_pulse_enable,
	output logic [3:0] ir_mode,
	output logic [3:0] tx_power
);
	typedef enum logic [2:0] {
		st_init, st_idle, st_cmd, st_wdata, st_ack, st_turn, st_resp, st_rwait
	} state_e;

	// ==========================================
	// Pin synchronisers
	logic sclk_m, sclk_s, sclk_d, tx_m, tx_s, ph_m, ph_s;
	logic rise, fall;

	// Two flip-flops per pin, one more for clock edges
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			tx_m <= 1'b0;
			tx_s <= 1'b0;
			ph_m <= 1'b1;
			ph_s <= 1'b1;
		end
		else
		begin
			sclk_m <= sclk;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			tx_m <= tx_write_line;
			tx_s <= tx_m;
			ph_m <= photo_rx;
			ph_s <= ph_m;
		end
	end

	// Serial clock edges
	assign rise = sclk_s & ~sclk_d;
	assign fall = ~sclk_s & sclk_d;

	// ==========================================
	// Transaction engine
	state_e state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [7:0] shreg, next_shreg, cmd, next_cmd;
	logic [4:0] init_cnt, next_init_cnt;
	logic [4:0] ctrl0, next_ctrl0;
	logic [3:0] ctrl1, next_ctrl1, ctrl2, next_ctrl2;
	logic hit, next_hit, resp, next_resp, led_en, next_led_en;
	logic drv, next_drv, next_rx_out, next_rx_oe_n, next_led_drive;
	logic [7:0] shifted, rdata;
	logic [2:0] addr;
	logic [3:0] idx;
	logic wr_ok, ack_now, resp_now;

	// Field decode of the shifted and held command
	assign shifted = {tx_s, shreg[7:1]};
	assign addr = cmd[CMD_ADDR_LSB +: 3];
	assign idx = cmd[CMD_IDX_LSB +: 4];
	assign rdata = (idx == IDX_CTRL0) ? {3'h0, ctrl0} :
		(idx == IDX_CTRL1) ? {4'h0, ctrl1} :
		(idx == IDX_CTRL2) ? {ctrl2, 4'h0} : 8'h00;
	assign wr_ok = (idx == IDX_CTRL0) || (idx == IDX_CTRL2) ||
		(idx == IDX_RESET) || ((idx == IDX_CTRL1) &&
		$onehot0(shreg[3:0]) && (shreg[7:4] == 4'h0));
	assign ack_now = wr_ok && (addr == ADDR_INDIV) && ctrl0[C0_ACK_PULSE_ENABLE] &&
		ctrl0[C0_RXOEN];
	assign resp_now = (addr == ADDR_INDIV) ||
		((addr == ADDR_BCAST) && ctrl0[C0_RXOEN]);

	// Next state of the engine
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_shreg = shreg;
		next_cmd = cmd;
		next_init_cnt = init_cnt;
		next_ctrl0 = ctrl0;
		next_ctrl1 = ctrl1;
		next_ctrl2 = ctrl2;
		next_hit = hit;
		next_resp = resp;
		next_led_en = led_en;
		next_drv = drv;
		next_rx_out = rx_out;
		case (state)
			st_init:
				if (rise)
				begin
					if (tx_s)
						next_init_cnt = 5'h00;
					else if (init_cnt == INIT_EDGES - 5'h01)
						next_state = st_idle;
					else
						next_init_cnt = init_cnt + 5'h01;
				end
			st_idle:
			begin
				if (fall)
					next_drv = 1'b0;
				if (rise)
				begin
					next_led_en = 1'b0;
					next_drv = 1'b0;
					next_cnt = 4'h0;
					next_state = st_cmd;
				end
			end
			st_cmd:
				if (rise)
				begin
					next_shreg = shifted;
					next_cnt = cnt + 4'h1;
					if (cnt == BYTE_LAST)
					begin
						next_cmd = shifted;
						next_cnt = 4'h0;
						next_hit = (shifted[CMD_ADDR_LSB +: 3] == ADDR_INDIV) ||
							(shifted[CMD_ADDR_LSB +: 3] == ADDR_BCAST);
						if (shifted[CMD_DIR_BIT])
							next_state = st_turn;
						else if (shifted[CMD_IDX_LSB +: 4] == IDX_RESET)
							next_state = st_ack;
						else
							next_state = st_wdata;
					end
				end
			st_wdata:
				if (rise)
				begin
					if (cnt != 4'h0)
						next_shreg = shifted;
					next_cnt = cnt + 4'h1;
					if (cnt == WBYTE_LAST)
						next_state = st_ack;
				end
			st_ack:
				if (rise)
				begin
					next_led_en = 1'b1;
					next_state = st_idle;
					if (hit && ack_now)
					begin
						next_drv = 1'b1;
						next_rx_out = 1'b0;
					end
					if (hit && wr_ok)
						case (idx)
							IDX_CTRL0: next_ctrl0 = {shreg[4], 1'b0, shreg[2:0]};
							IDX_CTRL1: next_ctrl1 = shreg[3:0];
							IDX_CTRL2: next_ctrl2 = shreg[7:4];
							IDX_RESET:
							begin
								next_ctrl0 = CTRL0_RST;
								next_ctrl1 = CTRL1_RST;
								next_ctrl2 = CTRL2_RST;
							end
							default: next_ctrl1 = ctrl1;
						endcase
					else if (hit && idx == IDX_CTRL1)
						next_ctrl1 = CTRL1_RST;
				end
			st_turn:
				if (rise)
				begin
					next_cnt = cnt + 4'h1;
					if (cnt == GAP_LAST)
					begin
						next_resp = hit && resp_now;
						next_drv = hit && resp_now;
						next_rx_out = RX_START;
						next_cnt = 4'h0;
						next_state = st_resp;
					end
				end
			st_resp:
				if (rise)
				begin
					next_rx_out = rdata[cnt[2:0]];
					next_cnt = cnt + 4'h1;
					if (cnt == BYTE_LAST)
						next_state = st_rwait;
				end
			st_rwait:
				if (!tx_s)
				begin
					next_drv = 1'b0;
					next_resp = 1'b0;
					next_led_en = 1'b1;
					next_state = st_idle;
				end
				else if (rise)
					next_rx_out = 1'b1;
			default: next_state = st_init;
		endcase
		// Read line and LED: photodiode only between transactions
		next_rx_oe_n = ~next_drv;
		if ((next_state == st_idle || next_state == st_init) && !next_drv)
		begin
			next_rx_out = ph_s;
			next_rx_oe_n = ~next_ctrl0[C0_RXOEN];
		end
		next_led_drive = tx_s & next_led_en & ctrl0[C0_TLED];
	end

	// Registers of the engine
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= st_init;
			cnt <= 4'h0;
			shreg <= 8'h00;
			cmd <= 8'h00;
			init_cnt <= 5'h00;
			ctrl0 <= CTRL0_RST;
			ctrl1 <= CTRL1_RST;
			ctrl2 <= CTRL2_RST;
			hit <= 1'b0;
			resp <= 1'b0;
			led_en <= 1'b1;
			drv <= 1'b0;
			rx_out <= 1'b1;
			rx_oe_n <= 1'b1;
			led_drive <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			shreg <= next_shreg;
			cmd <= next_cmd;
			init_cnt <= next_init_cnt;
			ctrl0 <= next_ctrl0;
			ctrl1 <= next_ctrl1;
			ctrl2 <= next_ctrl2;
			hit <= next_hit;
			resp <= next_resp;
			led_en <= next_led_en;
			drv <= next_drv;
			rx_out <= next_rx_out;
			rx_oe_n <= next_rx_oe_n;
			led_drive <= next_led_drive;
		end
	end

	// Configuration outputs straight from the control registers
	assign power_mode = ctrl0[C0_PWR];
	assign receiver_output_enable = ctrl0[C0_RXOEN];
	assign ack_pulse_enable = ctrl0[C0_ACK_PULSE_ENABLE];
	assign ir_mode = ctrl1;
	assign tx_power = ctrl2;

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_led_off_start: assert property (
		(state == st_idle) && rise |=> !led_en)
		else $error("LED not disabled at command start");
	a_led_back_end: assert property ((state == st_ack) && rise |=>
		led_en && (state == st_idle))
		else $error("LED not re-enabled at final clock");
	a_resp_gap: assert property ((state == st_turn) && rise &&
		(cnt == GAP_LAST) && hit && resp_now |=>
		!rx_oe_n && (rx_out == RX_START) && (state == st_resp))
		else $error("Response start bit not on fourth clock");
	a_ack_pulse: assert property ((state == st_ack) && rise && hit &&
		ack_now |=> !rx_oe_n && !rx_out)
		else $error("Acknowledge pulse missing");
	// Broadcast may leave the line enabled for the photodiode, never driven
	a_no_bcast_ack: assert property ((state == st_ack) && rise &&
		(addr == ADDR_BCAST) |=> !drv)
		else $error("Acknowledge given to broadcast");
	a_float_unaddr: assert property (
		(state == st_resp || state == st_rwait) && !resp |-> rx_oe_n)
		else $error("Unaddressed slave drives read line");
	// Only engine-driven values count; idle photodiode data moves freely
	a_rx_on_rise: assert property (drv && $past(drv) &&
		$changed(rx_out) |-> $past(rise))
		else $error("Read line changed off a rising edge");
	a_cfg_late: assert property ($changed(ctrl0) || $changed(ctrl1) ||
		$changed(ctrl2) |-> ($past(state) == st_ack) && $past(rise))
		else $error("Configuration applied before command end");
	a_read_end: assert property ((state == st_rwait) && !tx_s |=>
		(state == st_idle) && led_en ##1 (rx_oe_n == ~ctrl0[C0_RXOEN]))
		else $error("Read not ended by write line low");
	a_addr_hit: assert property ((state == st_cmd) && rise &&
		(cnt == BYTE_LAST) |=> hit == ((addr == ADDR_INDIV) ||
		(addr == ADDR_BCAST)))
		else $error("Address decode wrong");

	c_write_ack: cover property ((state == st_ack) && rise && hit && ack_now);
	c_read_resp: cover property ((state == st_resp) && resp && rise);
	c_reset_cmd: cover property ((state == st_ack) && rise && hit &&
		(idx == IDX_RESET));
	c_bcast_wr: cover property ((state == st_ack) && rise &&
		(addr == ADDR_BCAST));
endmodule

// ---- tb/ir_ctl_master.sv ----
// Controller model driving the serial clock and write line
`timescale 1ns/10ps
module ir_ctl_master
	import ir_ctl_pkg::*;
(
	// Clock
	input wire logic clk,
	// Serial bus
	output logic sclk,
	output logic tx_write_line,
	input wire logic rx_read_line,
	// Results
	output logic in_cmd,
	output logic res_stb,
	output logic [9:0] res_data
);
	logic s_pre;
	logic s_hi;

	// ====================
	// Idle levels
	initial
	begin
		sclk = 1'b0;
		tx_write_line = 1'b0;
		in_cmd = 1'b0;
		res_stb = 1'b0;
		res_data = 10'h000;
	end

	// One clock: data set at the fall, line sampled before each edge
	task automatic cyc(input logic v);
		tx_write_line = v;
		repeat (8) @(negedge clk);
		s_pre = rx_read_line;
		sclk = 1'b1;
		repeat (8) @(negedge clk);
		s_hi = rx_read_line;
		sclk = 1'b0;
	endtask

	// Hold the write line as LED data, clock stopped
	task automatic idle_tx(input logic v);
		tx_write_line = v;
		repeat (8) @(negedge clk);
	endtask

	// Power-up clocks with the write line low
	task automatic init;
		repeat (INIT_EDGES) cyc(1'b0);
	endtask

	// Start bit, then the byte least significant bit first
	task automatic byte_out(input logic [7:0] b);
		cyc(TX_START);
		in_cmd = 1'b1;
		for (int i = 0; i < 8; i++)
			cyc(b[i]);
	endtask

	// Hand a result to the bench
	task automatic post(input logic [9:0] r);
		res_data = r;
		res_stb = 1'b1;
		@(negedge clk);
		res_stb = 1'b0;
		in_cmd = 1'b0;
	endtask

	// Write or special command, then the final clock
	task automatic wr(input logic [2:0] a, input logic [3:0] i,
		input logic [7:0] d);
		byte_out({i, 1'b0, a});
		if (i != IDX_RESET)
			byte_out(d);
		cyc(1'b0);
		post({9'h000, s_hi});
	endtask

	// Read: write line high after the command, low to end it
	task automatic rd(input logic [2:0] a, input logic [3:0] i);
		logic [9:0] r;
		byte_out({i, 1'b1, a});
		for (int k = 9; k < 22; k++)
		begin
			cyc(1'b1);
			if (k == 12)
				r[9] = s_pre;
			else if (k == 13)
				r[8] = s_pre;
			else if (k > 13)
				r[k - 14] = s_pre;
		end
		tx_write_line = 1'b0;
		repeat (16) @(negedge clk);
		post(r);
	endtask
endmodule

// ---- tb/ir_transceiver_serial_ctrl_bench.sv ----
// Bench of the transceiver serial control slave
`timescale 1ns/10ps
module ir_transceiver_serial_ctrl_bench;
	import ir_ctl_pkg::*;
	logic clk, rst_b, photo_rx, sclk, tx_write_line, in_cmd, res_stb;
	logic rx_out, rx_oe_n, led_drive, power_mode;
	logic receiver_output_enable, ack_pulse_enable;
	logic [3:0] ir_mode, tx_power, c1, c2;
	logic [4:0] c0;
	logic [9:0] res_data;
	logic [9:0] notes[$];
	int mismatches = 0;
	int samples_checked = 0;
	// Read line with its pull-up
	wire logic rx_read_line = rx_oe_n ? 1'b1 : rx_out;
	wire logic [10:0] cfg = {power_mode, receiver_output_enable,
		ack_pulse_enable, ir_mode, tx_power};

	// ====================
	// Clock, parts
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	ir_ctl_slave DUT (.clk(clk), .rst_b(rst_b), .sclk(sclk),
		.tx_write_line(tx_write_line), .photo_rx(photo_rx), .rx_out(rx_out),
		.rx_oe_n(rx_oe_n), .led_drive(led_drive), .power_mode(power_mode),
		.receiver_output_enable(receiver_output_enable),
		.ack_pulse_enable(ack_pulse_enable), .ir_mode(ir_mode),
		.tx_power(tx_power));
	ir_ctl_master m (.clk(clk), .sclk(sclk), .tx_write_line(tx_write_line),
		.rx_read_line(rx_read_line), .in_cmd(in_cmd), .res_stb(res_stb),
		.res_data(res_data));

	// ====================
	// Comparisons and verdict
	task automatic compare_link(input logic [9:0] e, input logic [9:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: expected %h, got %h", $time, e, g);
		end
	endtask

	task automatic compare_port(input logic [10:0] e, input logic [10:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: expected %h, got %h", $time, e, g);
		end
	endtask

	task automatic give_verdict;
		if (mismatches == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Configuration outputs against the model
	task automatic check_cfg;
		logic [10:0] e;
		e = {c0[C0_PWR], c0[C0_RXOEN], c0[C0_ACK_PULSE_ENABLE], c1, c2};
		compare_port(e, cfg);
	endtask

	// Write with its expected acknowledge, then model update
	task automatic do_wr(input logic [2:0] a, input logic [3:0] i,
		input logic [7:0] d);
		logic ok;
		logic ack;
		ok = (i <= IDX_CTRL2) || (i == IDX_RESET);
		if (i == IDX_CTRL1 && (d[7:4] != 4'h0 || $countones(d[3:0]) > 1))
			ok = 1'b0;
		ack = ok && a == ADDR_INDIV && c0[C0_ACK_PULSE_ENABLE] && c0[C0_RXOEN];
		notes.push_back({9'h000, !ack});
		m.wr(a, i, d);
		if (a == ADDR_INDIV || a == ADDR_BCAST)
			case (i)
				IDX_CTRL0: c0 = d[4:0] & 5'h17;
				IDX_CTRL1: c1 = ok ? d[3:0] : 4'h0;
				IDX_CTRL2: c2 = d[7:4];
				IDX_RESET: {c0, c1, c2} = {CTRL0_RST, CTRL1_RST, CTRL2_RST};
				default: c1 = c1;
			endcase
	endtask

	// Read with its expected answer
	task automatic do_rd(input logic [2:0] a, input logic [3:0] i);
		logic [7:0] b;
		case (i)
			IDX_CTRL0: b = {3'h0, c0};
			IDX_CTRL1: b = {4'h0, c1};
			IDX_CTRL2: b = {c2, 4'h0};
			default: b = 8'h00;
		endcase
		if (a == ADDR_INDIV || (a == ADDR_BCAST && c0[C0_RXOEN]))
			notes.push_back({2'h2, b});
		else
			notes.push_back(10'h3ff);
		m.rd(a, i);
	endtask

	// Take the oldest note on each result and compare
	always @(posedge clk)
		if (res_stb === 1'b1 && notes.size() > 0)
			compare_link(notes.pop_front(), res_data);

	// Emitter stays dark while a command runs; sampled off the launch edge
	always @(negedge clk)
		if (in_cmd === 1'b1)
			compare_port(11'h000, {10'h000, led_drive});

	// Hang guard
	initial
	begin
		repeat (60000) @(posedge clk);
		mismatches++;
		give_verdict;
	end

	// ====================
	// Main sequence
	initial
	begin
		rst_b = 1'b0;
		photo_rx = 1'b1;
		{c0, c1, c2} = {CTRL0_RST, CTRL1_RST, CTRL2_RST};
		void'($urandom(39490));
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		check_cfg;
		compare_port(11'h001, {10'h000, rx_read_line});
		m.init();
		m.idle_tx(1'b1);
		compare_port(11'h001, {10'h000, led_drive});
		m.idle_tx(1'b0);
		do_wr(ADDR_BCAST, IDX_CTRL0, 8'h17);
		m.idle_tx(1'b1);
		compare_port(11'h001, {10'h000, led_drive});
		m.idle_tx(1'b0);
		check_cfg;
		for (int n = 0; n < 4; n++)
		begin
			do_wr(ADDR_INDIV, IDX_CTRL2, 8'($urandom_range(15, 0)) << 4);
			do_wr(ADDR_INDIV, IDX_CTRL1, 8'h01 << $urandom_range(3, 0));
			check_cfg;
			for (int i = 0; i < 4; i++)
				do_rd(ADDR_INDIV, 4'(i));
		end
		do_wr(3'h2, IDX_CTRL2, 8'hf0);
		do_rd(3'h2, IDX_CTRL0);
		do_wr(ADDR_INDIV, IDX_CTRL1, 8'h03);
		photo_rx = 1'b0;
		do_rd(ADDR_INDIV, IDX_CTRL1);
		photo_rx = 1'b1;
		do_wr(ADDR_INDIV, IDX_CTRL0, 8'h05);
		do_rd(ADDR_INDIV, IDX_CTRL0);
		do_rd(ADDR_BCAST, IDX_CTRL0);
		do_wr(ADDR_INDIV, IDX_RESET, 8'h00);
		check_cfg;
		repeat (8) @(negedge clk);
		if (notes.size() != 0)
			mismatches++;
		give_verdict;
	end
endmodule
